// ### rtl/pld_test_port.sv
// power-up clear, preload and observe around the macrocell registers
// assumes test pins arrive from a tester asynchronously; product terms
// and async terms are same-clock logic from the array outside
//
// How it works
// - power-up clears every flip-flop to zero
// - pin level follows programmed output polarity outside test modes
// - clear finishes within ten microseconds
// - preload loads flip-flops from I/O pins
// - observe overrides enables, turns buffers on
// - observe shows pin and buried registers
// - async reset/preset acts, may overwrite preload
// - test modes force combinational cells registered
// - combinational outputs recover after test
`timescale 1ns/1ps
module pld_test_port
  import pld_test_pkg::*;
#(
  parameter int unsigned N            = NUM_CELLS,
  parameter int unsigned CLEAR_CYCLES_P = CLEAR_CYCLES
) (
  input  wire logic         clk_i,         // 100 MHz clock
  input  wire logic         reset_n_i,     // power-on reset, active low
  input  wire logic         test_en_i,     // tester asserts test mode
  input  wire logic         preload_i,     // 1 preload, 0 observe
  input  wire logic [N-1:0] pin_in_i,      // I/O pin input levels
  input  wire logic [N-1:0] pt_d_i,        // product-term next values
  input  wire logic [N-1:0] comb_val_i,    // combinational results
  input  wire logic [N-1:0] oe_prog_i,     // programmed output enables
  input  wire logic [N-1:0] invert_i,      // programmed output polarity
  input  wire logic [N-1:0] is_comb_i,     // cell set combinational
  input  wire logic [N-1:0] ar_i,          // async reset terms
  input  wire logic [N-1:0] ap_i,          // async preset terms
  output logic      [N-1:0] pin_out_o,     // pin output levels
  output logic      [N-1:0] pin_oe_n_o,    // pin enable, low drives
  output logic      [N-1:0] reg_q_o,       // register feedback
  output logic              ready_o        // power-up clear finished
);
  cell_bus_if #(.N(N)) bus ();

  // two-stage synchronisers for tester pins
  logic [N+1:0] sync1;
  logic [N+1:0] sync2;
  logic         test_en;
  logic         preload;
  logic [N-1:0] pins;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {test_en_i, preload_i, pin_in_i};
      sync2 <= sync1;
    end
  end
  assign test_en = sync2[N+1];
  assign preload = sync2[N];
  assign pins    = sync2[N-1:0];

  // state and clear counter
  test_state_e            state;
  test_state_e            next_state;
  logic [CLEAR_CNT_W-1:0] cnt;
  logic [CLEAR_CNT_W-1:0] next_cnt;

  // clear runs a fixed count after reset release, no external input
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_CLEAR: begin
        if (cnt >= CLEAR_CNT_W'(CLEAR_CYCLES_P - 1)) begin
          next_state = ST_NORMAL;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      ST_NORMAL, ST_LOAD, ST_SHOW: begin
        if (!test_en) begin
          next_state = ST_NORMAL;
        end else if (preload) begin
          next_state = ST_LOAD;
        end else begin
          next_state = ST_SHOW;
        end
      end
      default: next_state = ST_CLEAR;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_CLEAR;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  logic in_test;
  assign in_test = (state == ST_LOAD) || (state == ST_SHOW);

  // drive register array; product terms held at zero during test
  assign bus.clear    = (state == ST_CLEAR);
  assign bus.load     = (state == ST_LOAD);
  assign bus.load_val = pins;
  assign bus.d        = in_test ? '0 : pt_d_i;

  cell_regs #(.N(N)) u_regs (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ar_i      (ar_i),
    .ap_i      (ap_i),
    .bus       (bus)
  );

  // pin outputs registered; polarity applied before the register
  logic [N-1:0] pin_out;
  logic [N-1:0] next_pin_out;
  logic [N-1:0] oe_n;
  logic [N-1:0] next_oe_n;

  always_comb begin
    next_pin_out = '0;
    next_oe_n    = '1;
    for (int i = 0; i < N; i++) begin
      if (state == ST_SHOW) begin
        next_pin_out[i] = bus.q[i];
        next_oe_n[i]    = 1'b0;
      end else if (state == ST_LOAD) begin
        next_pin_out[i] = 1'b0;  // pins are inputs while loading
        next_oe_n[i]    = 1'b1;
      end else begin
        // combinational cells recompute once test ends
        next_pin_out[i] = (is_comb_i[i] ? comb_val_i[i] : bus.q[i])
                          ^ invert_i[i];
        next_oe_n[i]    = ~oe_prog_i[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_out <= '0;
      oe_n    <= '1;
    end else begin
      pin_out <= next_pin_out;
      oe_n    <= next_oe_n;
    end
  end

  assign pin_out_o  = pin_out;
  assign pin_oe_n_o = oe_n;
  assign reg_q_o    = bus.q;
  assign ready_o    = (state != ST_CLEAR);  // clock-low wait is system's

  // cycles since reset release, counted apart from cnt so the clear
  // deadline is held against elapsed time, not the counter that ends it
  logic [CLEAR_CNT_W:0] up_cycles;
  logic [CLEAR_CNT_W:0] next_up_cycles;

  // saturates once the top bit sets, well past any clear interval
  always_comb begin
    next_up_cycles = up_cycles;
    if (!up_cycles[CLEAR_CNT_W]) begin
      next_up_cycles = up_cycles + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      up_cycles <= '0;
    end else begin
      up_cycles <= next_up_cycles;
    end
  end

  // checks sit beside the state machine and pin registers they guard
  AST_CLEAR_BOUND: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == ST_CLEAR) |-> (cnt < CLEAR_CNT_W'(CLEAR_CYCLES_P)))
    else $error("power-up clear overran its interval");
  AST_CLEAR_DEADLINE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (up_cycles >= {1'b0, CLEAR_CNT_W'(CLEAR_CYCLES_P)})
      |-> (state != ST_CLEAR))
    else $error("power-up clear outlasted its interval");
  AST_CLEAR_EXIT: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == ST_CLEAR && cnt == CLEAR_CNT_W'(CLEAR_CYCLES_P - 1))
      |=> (state == ST_NORMAL))
    else $error("power-up clear did not end on time");
  AST_OBSERVE_DRIVE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == ST_SHOW) |=> (oe_n == '0))
    else $error("observe did not enable all buffers");
  AST_SHOW_ENTRY: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (test_en && !preload && state != ST_CLEAR) |=> (state == ST_SHOW))
    else $error("observe request not taken");
  AST_OBSERVE_DATA: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == ST_SHOW) |=> (pin_out == $past(bus.q)))
    else $error("observed pins differ from registers");
  AST_POLARITY: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == ST_NORMAL && is_comb_i == '0)
      |=> (pin_out == ($past(bus.q) ^ $past(invert_i))))
    else $error("output polarity not applied");
  AST_PRELOAD: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == ST_LOAD && ar_i == '0 && ap_i == '0)
      |=> (bus.q == $past(pins)))
    else $error("preload did not load pin values");
  AST_LOAD_ENTRY: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (test_en && preload && state != ST_CLEAR) |=> (state == ST_LOAD))
    else $error("preload request not taken");
  AST_LOAD_FLOAT: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == ST_LOAD) |=> (oe_n == '1))
    else $error("pins driven while preloading");
  AST_PT_ZERO: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == ST_SHOW && ap_i == '0) |=> (bus.q == '0))
    else $error("product terms not forced low in test");
  AST_MODE_GATE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (!test_en && state != ST_CLEAR) |=> (state == ST_NORMAL))
    else $error("test mode held without tester request");
  AST_NORMAL_OE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (state == ST_NORMAL) |=> (oe_n == ~$past(oe_prog_i)))
    else $error("programmed enables not followed");
  AST_COMB_BACK: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ($past(in_test) && state == ST_NORMAL)
      |=> (pin_out == ((($past(is_comb_i) & $past(comb_val_i))
        | (~$past(is_comb_i) & $past(bus.q))) ^ $past(invert_i))))
    else $error("combinational output not restored");
endmodule : pld_test_port

// ### shared/pld_test_pkg.sv
// constants and types for the macrocell test-access block
// assumes one 100 MHz clock and an asynchronous active-low reset
package pld_test_pkg;
  localparam int unsigned NUM_CELLS          = 8;
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned CLEAR_INTERVAL_US  = 10;
  // longest time, rounded down to whole cycles
  localparam int unsigned CLEAR_CYCLES       =
    (CLEAR_INTERVAL_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_CNT_W        = 11;
  localparam logic [NUM_CELLS-1:0] REG_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_CLEAR  = 2'b00,
    ST_NORMAL = 2'b01,
    ST_LOAD   = 2'b10,
    ST_SHOW   = 2'b11
  } test_state_e;
endpackage : pld_test_pkg

// ### shared/cell_bus_if.sv
// bundle between the control module and the register array
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface cell_bus_if #(parameter int unsigned N = 8);
  logic         clear;     // synchronous clear of all cells
  logic         load;      // preload strobe
  logic [N-1:0] load_val;  // preload values from the pins
  logic [N-1:0] d;         // product-term next values
  logic [N-1:0] q;         // stored register contents
  modport ctrl (output clear, output load, output load_val, output d,
                input q);
  modport cells (input clear, input load, input load_val, input d,
                 output q);
endinterface : cell_bus_if

// ### rtl/cell_regs.sv
// macrocell flip-flop array with clear, preload and async reset/preset
// assumes async terms already decoded from the stored contents
`timescale 1ns/1ps
module cell_regs
  import pld_test_pkg::*;
#(
  parameter int unsigned N = NUM_CELLS
) (
  input  wire logic         clk_i,      // system clock
  input  wire logic         reset_n_i,  // async reset, active low
  input  wire logic [N-1:0] ar_i,       // per-cell async reset term
  input  wire logic [N-1:0] ap_i,       // per-cell async preset term
  cell_bus_if.cells         bus         // control side
);
  logic [N-1:0] q;
  logic [N-1:0] next_q;

  // async terms override preload; priority clear, reset, preset, load
  always_comb begin
    next_q = q;
    if (bus.clear) begin
      next_q = '0;
    end else begin
      if (bus.load) begin
        next_q = bus.load_val;
      end else begin
        next_q = bus.d;
      end
      next_q = (next_q & ~ar_i) | (ap_i & ~ar_i);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= REG_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign bus.q = q;

  AST_CLEAR_ZERO: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    bus.clear |=> (q == '0))
    else $error("clear did not zero cells");
  AST_ASYNC_WINS: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (!bus.clear && (ar_i != '0)) |=> ((q & $past(ar_i)) == '0))
    else $error("async reset term did not act");
endmodule : cell_regs

// ### dv/pld_tester.sv
// tester model: drives the test-mode pins of the macrocell test port
// assumes a command (0 idle, 1 preload, 2 observe) from the bench
`timescale 1ns/1ps
module pld_tester (
  input  wire logic       clk_i,   // system clock
  input  wire logic [1:0] mode_i,  // requested test activity
  input  wire logic [7:0] val_i,   // preload pattern
  output logic            en_o,    // test mode request
  output logic            pre_o,   // 1 preload, 0 observe
  output logic      [7:0] pin_o    // levels on the io pins
);
  // one process owns every output, so each has a single driver;
  // pins not used for preload wander, so stale values never look valid
  initial begin
    en_o  = 1'b0;
    pre_o = 1'b0;
    pin_o = 8'h00;
    forever begin
      @(posedge clk_i);
      en_o  <= (mode_i != 2'd0);
      pre_o <= (mode_i == 2'd1) ? 1'b1 : ~pre_o & (mode_i == 2'd0);
      // bench picks patterns that keep async terms quiet unless meant
      pin_o <= (mode_i == 2'd1) ? val_i : ~pin_o;
    end
  end
endmodule : pld_tester

// ### dv/pld_test_port_tb.sv
// bench for the power-up clear, preload and observe port
// assumes the tester model beside it and a 100 MHz clock
`timescale 1ns/1ps
module pld_test_port_tb;
  import pld_test_pkg::*;
  localparam int unsigned CLR = 4;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [1:0] mode = 2'd0;
  logic [7:0] val = 8'h00;
  logic       test_en, preload, ready;
  logic [7:0] pin_in, pin_out, pin_oe_n, reg_q;
  logic [7:0] pt_d = 8'h00, comb_val = 8'h00, oe_prog = 8'h3c;
  logic [7:0] invert = 8'ha5, is_comb = 8'h00, ar = 8'h00, ap = 8'h00;
  int failures = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  pld_tester tester (.clk_i(clk_i), .mode_i(mode), .val_i(val),
    .en_o(test_en), .pre_o(preload), .pin_o(pin_in));
  pld_test_port #(.N(8), .CLEAR_CYCLES_P(CLR)) uut (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .test_en_i(test_en), .preload_i(preload),
    .pin_in_i(pin_in), .pt_d_i(pt_d), .comb_val_i(comb_val),
    .oe_prog_i(oe_prog), .invert_i(invert), .is_comb_i(is_comb),
    .ar_i(ar), .ap_i(ap), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n),
    .reg_q_o(reg_q), .ready_o(ready));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  // clear during reset, ready after the shortened interval
  task automatic t_powerup;
    step(1);
    chk(reg_q, 8'h00);
    chk(pin_oe_n, 8'hff);
    chk({7'h00, ready}, 8'h00);
    @(posedge clk_i) reset_n_i <= 1'b1;
    // inputs and tester stay idle until clear ends and setup is met
    step(CLR - 1);
    chk({7'h00, ready}, 8'h00);
    step(1);
    chk({7'h00, ready}, 8'h01);
    chk(reg_q, 8'h00);
    step(2);
    chk(pin_out, invert);
    chk(pin_oe_n, ~oe_prog);
    $display("test powerup done");
  endtask : t_powerup
  // preload, then a preload that trips the async terms
  task automatic t_preload;
    @(posedge clk_i) begin
      mode <= 2'd1;
      val  <= 8'h3c;
    end
    step(7);
    chk(reg_q, 8'h3c);
    chk(pin_oe_n, 8'hff);
    @(posedge clk_i) begin
      val <= 8'hf0;
      ar  <= 8'h10;
      ap  <= 8'h01;
    end
    step(7);
    chk(reg_q, 8'he1);
    @(posedge clk_i) begin
      ar <= 8'h00;
      ap <= 8'h00;
    end
    $display("test preload done");
  endtask : t_preload
  // observe drives every pin; preset shows on buried and pin cells
  task automatic t_observe;
    @(posedge clk_i) begin
      mode     <= 2'd2;
      oe_prog  <= 8'h00;
      is_comb  <= 8'h0f;
      comb_val <= 8'hff;
      ap       <= 8'h81;
    end
    step(7);
    chk(pin_oe_n, 8'h00);
    chk(reg_q, 8'h81);
    chk(pin_out, 8'h81);
    @(posedge clk_i) ap <= 8'h00;
    step(3);
    chk(reg_q, 8'h00);
    chk(pin_out, 8'h00);
    $display("test observe done");
  endtask : t_observe
  // back to normal: product terms load, comb outputs recover
  task automatic t_normal;
    @(posedge clk_i) begin
      mode     <= 2'd0;
      pt_d     <= 8'h5a;
      comb_val <= 8'h05;
      oe_prog  <= 8'h0f;
    end
    step(7);
    chk(reg_q, 8'h5a);
    chk(pin_out, 8'hf0);
    chk(pin_oe_n, 8'hf0);
    $display("test normal done");
  endtask : t_normal
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  // whole run is near 45 cycles, so 2000 leaves ample margin
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
  initial begin
    t_powerup();
    t_preload();
    t_observe();
    t_normal();
    report_and_stop();
  end
endmodule : pld_test_port_tb
